// File: hdl/power_on_ack_reset_domains.sv
// Power-on acknowledge, boot selection and three-level reset domain control.
`timescale 1ns/1ns
`default_nettype none
module power_on_ack_reset_domains #(
	parameter int unsigned TICK_CYCLES = pwr_ack_pkg::TICK_CYCLES_DEF
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire pwr_ack_pkg::reg_req_t reg_req_i,
	output logic [pwr_ack_pkg::DATA_W-1:0] reg_rdata_o,
	input wire logic on_request_i,
	input wire logic keep_alive_pin_i,
	input wire logic boot_sel_i,
	input wire logic sleep_request_i,
	input wire logic [pwr_ack_pkg::SRC_W-1:0] int_src_i,
	output logic reset_out_o,
	output logic int_n_o,
	output pwr_ack_pkg::seq_out_t seq_o
);
	import pwr_ack_pkg::*;

	core_t q;
	core_t d;
	logic hold;
	logic hold_fell;
	logic on_rise;
	logic running;
	logic seq_done;
	logic off_req;
	logic level_hw;
	logic pending;
	logic [DATA_W-1:0] up_len;
	logic [CFG_W-1:0] offset;

	function automatic logic [CFG_W-1:0] region_base(input logic sel);
		return sel ? REGION1_BASE : REGION0_BASE;
	endfunction : region_base

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	always_comb begin
		d = q;
		level_hw = 1'b0;
		d.sync1 = {sleep_request_i, boot_sel_i, keep_alive_pin_i, on_request_i};
		d.sync2 = q.sync1;
		d.on_prev = q.sync2[SYNC_ON];
		on_rise = q.sync2[SYNC_ON] & ~q.on_prev;
		// The host keeps the device up with the pin or with the bit.
		hold = q.mode[AUTO_MODE_BIT] ? q.keep_on : q.sync2[SYNC_HOLD];
		d.hold_prev = hold;
		hold_fell = q.hold_prev & ~hold;
		running = (q.state == ST_UP) || (q.state == ST_DOWN);

		if (q.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
			d.tick_cnt = '0;
			d.tick = 1'b1;
		end else begin
			d.tick_cnt = q.tick_cnt + 1'b1;
			d.tick = 1'b0;
		end

		// The live boot level picks the branch of the power-up sequence.
		up_len = q.sync2[SYNC_BOOT] ? q.up_len1 : q.up_len0;
		if (q.state == ST_UP) begin
			seq_done = q.step >= up_len;
		end else begin
			seq_done = q.step >= q.down_len;
		end

		if (((q.state == ST_ACTIVE) || (q.state == ST_SLEEP)) && q.tick
				&& !q.win_done) begin
			d.win_cnt = q.win_cnt + 1'b1;
		end
		d.win_done = d.win_cnt == ACTIVE_WINDOW_TICKS;
		off_req = ((q.state == ST_ACTIVE) || (q.state == ST_SLEEP))
			&& (hold_fell || (q.win_done && !hold));

		if (reg_req_i.wr) begin
			case (reg_req_i.addr)
				ADDR_DEVICE_CTRL: begin
					d.keep_on = reg_req_i.wdata[KEEP_ON_BIT];
				end
				ADDR_POWER_CTRL: begin
					d.sleep_allow = reg_req_i.wdata[SLEEP_ALLOW_BIT];
				end
				ADDR_OFF_CAUSE: begin
					d.off_cause = q.off_cause & ~reg_req_i.wdata;
				end
				ADDR_CONV_MASK: begin
					d.conv_mask = reg_req_i.wdata;
				end
				default: begin
				end
			endcase
			// Settings loaded by a sequence may not be changed under it.
			if (!running) begin
				case (reg_req_i.addr)
					ADDR_MODE: begin
						d.mode = reg_req_i.wdata;
					end
					ADDR_OFF_LEVEL: begin
						d.off_level = reg_req_i.wdata;
					end
					ADDR_UP_LEN0: begin
						d.up_len0 = reg_req_i.wdata;
					end
					ADDR_UP_LEN1: begin
						d.up_len1 = reg_req_i.wdata;
					end
					ADDR_DOWN_LEN: begin
						d.down_len = reg_req_i.wdata;
					end
					ADDR_INT_CTRL: begin
						d.int_ctrl = reg_req_i.wdata;
					end
					default: begin
					end
				endcase
			end
		end

		case (q.state)
			ST_OFF: begin
				if (on_rise) begin
					d.state = ST_UP;
					d.step = '0;
					d.seq.seq_sel = q.sync2[SYNC_BOOT];
				end
			end
			ST_UP: begin
				if (seq_done) begin
					d.state = ST_ACTIVE;
					d.win_cnt = '0;
					d.win_done = 1'b0;
					d.boot_status = {{(DATA_W-1){1'b0}}, q.sync2[SYNC_BOOT]};
					if (q.mode[AUTO_MODE_BIT] && !q.mode[AUTO_SET_DIS_BIT]) begin
						d.keep_on = 1'b1;
					end
				end else if (q.tick) begin
					d.step = q.step + 1'b1;
				end
			end
			ST_ACTIVE, ST_SLEEP: begin
				if (off_req) begin
					d.state = ST_DOWN;
					d.step = '0;
					d.down_cause = hold_fell;
					d.seq.down_from_sleep = q.state == ST_SLEEP;
					if (hold_fell) begin
						d.off_cause[CAUSE_HOLD_FALL] = 1'b1;
					end else begin
						d.off_cause[CAUSE_WINDOW] = 1'b1;
					end
				end else if ((q.state == ST_ACTIVE) && q.sleep_allow
						&& q.sync2[SYNC_SLEEP]) begin
					d.state = ST_SLEEP;
				end else if ((q.state == ST_SLEEP) && !q.sync2[SYNC_SLEEP]) begin
					d.state = ST_ACTIVE;
					d.win_cnt = '0;
					d.win_done = 1'b0;
				end
			end
			ST_DOWN: begin
				if (seq_done) begin
					d.state = ST_OFF;
					level_hw = q.off_level[q.down_cause];
					// Cause and converter mask are left alone by both levels.
					d.keep_on = 1'b0;
					d.sleep_allow = CORE_RST.sleep_allow;
					if (level_hw) begin
						d.mode = MODE_RST;
						d.off_level = OFF_LEVEL_RST;
						d.up_len0 = UP_LEN0_RST;
						d.up_len1 = UP_LEN1_RST;
						d.down_len = DOWN_LEN_RST;
						d.int_ctrl = INT_CTRL_RST;
						d.boot_status = '0;
					end
				end else if (q.tick) begin
					d.step = q.step + 1'b1;
				end
			end
			default: begin
				d.state = ST_OFF;
			end
		endcase

		// The address walks the selected region and parks on its last word.
		if (q.step > {1'b0, REGION_SPAN}) begin
			offset = REGION_SPAN;
		end else begin
			offset = q.step[CFG_W-1:0];
		end
		d.seq.cfg_addr = region_base(d.seq.seq_sel) + offset;
		d.seq.running = (d.state == ST_UP) || (d.state == ST_DOWN);
		d.reset_out = (d.state == ST_ACTIVE) || (d.state == ST_SLEEP);

		pending = |(int_src_i & ~q.int_ctrl[INT_SRC_MASK_LSB +: SRC_W]);
		d.int_n = ~(pending && !((q.state == ST_SLEEP)
			&& q.int_ctrl[INT_MASK_SLEEP_BIT]));

		d.rdata = '0;
		if (reg_req_i.rd) begin
			case (reg_req_i.addr)
				ADDR_DEVICE_CTRL: d.rdata[KEEP_ON_BIT] = q.keep_on;
				ADDR_POWER_CTRL: d.rdata[SLEEP_ALLOW_BIT] = q.sleep_allow;
				ADDR_MODE: d.rdata = q.mode;
				ADDR_OFF_LEVEL: d.rdata = q.off_level;
				ADDR_UP_LEN0: d.rdata = q.up_len0;
				ADDR_UP_LEN1: d.rdata = q.up_len1;
				ADDR_DOWN_LEN: d.rdata = q.down_len;
				ADDR_INT_CTRL: d.rdata = q.int_ctrl;
				ADDR_BOOT_STATUS: d.rdata = q.boot_status;
				ADDR_OFF_CAUSE: d.rdata = q.off_cause;
				ADDR_CONV_MASK: d.rdata = q.conv_mask;
				ADDR_STATE: d.rdata = {3'h0, q.state};
				default: d.rdata = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register; the power-on reset clears every domain.

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= CORE_RST;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata_o = q.rdata;
	assign reset_out_o = q.reset_out;
	assign int_n_o = q.int_n;
	assign seq_o = q.seq;

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_up_done;
		(q.state == ST_UP) && (q.step >= up_len);
	endsequence

	sequence s_down_done;
		(q.state == ST_DOWN) && (q.step >= q.down_len);
	endsequence

	a_reset_out_state: assert property (
		reset_out_o == ((q.state == ST_ACTIVE) || (q.state == ST_SLEEP)))
		else $error("Reset output disagrees with power state.");

	a_up_release: assert property (
		s_up_done |=> reset_out_o && (q.state == ST_ACTIVE))
		else $error("Reset not released at end of power-up.");

	a_window_expiry: assert property (
		(q.state == ST_ACTIVE) && q.win_done && !hold |=> q.state == ST_DOWN)
		else $error("Active window expired without shutdown.");

	a_hold_fall_off: assert property (
		(q.state == ST_ACTIVE) && q.hold_prev && !hold
		|=> (q.state == ST_DOWN) && q.off_cause[CAUSE_HOLD_FALL])
		else $error("Keep-alive falling edge not taken as OFF.");

	a_keep_on_set: assert property (
		s_up_done ##0 (q.mode[AUTO_MODE_BIT] && !q.mode[AUTO_SET_DIS_BIT])
		|=> q.keep_on [*2])
		else $error("Keep-on bit not set after power-up.");

	a_boot_latched: assert property (
		s_up_done |=> q.boot_status[0] == $past(q.sync2[SYNC_BOOT]))
		else $error("Boot level not captured.");

	a_settings_locked: assert property (
		(q.state == ST_UP) && reg_req_i.wr && (reg_req_i.addr == ADDR_DOWN_LEN)
		|=> $stable(q.down_len))
		else $error("Setting changed during a sequence.");

	a_hw_clear: assert property (
		s_down_done ##0 q.off_level[q.down_cause]
		|=> (q.mode == MODE_RST) && !q.keep_on && (q.state == ST_OFF))
		else $error("Hardware reset left registers set.");

	a_por_keep: assert property (
		s_down_done ##0 !reg_req_i.wr |=> $stable(q.off_cause)
		&& $stable(q.conv_mask))
		else $error("Power-on domain disturbed by a switch-off.");

	a_swo_only: assert property (
		s_down_done ##0 !q.off_level[q.down_cause] ##0 !reg_req_i.wr
		|=> $stable(q.mode) && !q.keep_on)
		else $error("Switch-off reset touched hardware domain.");

	a_int_sleep_mask: assert property (
		(q.state == ST_SLEEP) && q.int_ctrl[INT_MASK_SLEEP_BIT]
		&& $stable(q.state) |=> int_n_o)
		else $error("Interrupt not masked in sleep.");

	a_int_pending: assert property (
		(q.state == ST_ACTIVE) && (|(int_src_i
		& ~q.int_ctrl[INT_SRC_MASK_LSB +: SRC_W])) |=> !int_n_o)
		else $error("Pending interrupt not driven low.");

	sequence s_power_on;
		(q.state == ST_OFF) && on_rise;
	endsequence

	a_on_start: assert property (
		s_power_on |=> (q.state == ST_UP) && q.seq.running && (q.step == '0))
		else $error("ON request did not start power-up.");

	a_region_select: assert property (
		s_power_on |=> q.seq.seq_sel == $past(q.sync2[SYNC_BOOT]))
		else $error("Sequence selector not taken from boot level.");

	a_cfg_in_region: assert property (
		(q.seq.cfg_addr >= region_base(q.seq.seq_sel)) && (q.seq.cfg_addr
		<= region_base(q.seq.seq_sel) + REGION_SPAN))
		else $error("Configuration address left its region.");

	a_up_hold: assert property (
		(q.state == ST_UP) && (q.step < (q.sync2[SYNC_BOOT] ? q.up_len1
		: q.up_len0)) |=> q.state == ST_UP)
		else $error("Power-up ended before its selected length.");

	a_window_restart: assert property (
		s_up_done |=> (q.win_cnt == '0) && !q.win_done)
		else $error("Active window did not restart.");

	a_wake_restart: assert property (
		(q.state == ST_SLEEP) && !q.sync2[SYNC_SLEEP] && !off_req
		|=> (q.state == ST_ACTIVE) && (q.win_cnt == '0))
		else $error("Active window did not restart on wake.");

	a_window_bound: assert property (
		q.win_cnt <= ACTIVE_WINDOW_TICKS)
		else $error("Active window counter overran.");

	a_tick_single: assert property (
		q.tick |=> !q.tick)
		else $error("Tick enable lasted more than one cycle.");

	a_auto_stays: assert property (
		(q.state == ST_ACTIVE) && q.mode[AUTO_MODE_BIT] && q.keep_on
		|=> reset_out_o)
		else $error("Device left active with keep-on bit set.");

	a_bit_replaces_pin: assert property (
		(q.state == ST_ACTIVE) && q.mode[AUTO_MODE_BIT] && q.hold_prev
		&& !q.keep_on |=> q.state == ST_DOWN)
		else $error("Keep-on bit clear not taken as OFF.");

	a_down_to_off: assert property (
		s_down_done |=> (q.state == ST_OFF) && !q.seq.running)
		else $error("Power-down did not end in OFF.");

	a_off_from_sleep: assert property (
		(q.state == ST_SLEEP) && off_req
		|=> (q.state == ST_DOWN) && q.seq.down_from_sleep && !reset_out_o)
		else $error("OFF request in sleep not taken.");

	a_hw_domain: assert property (
		s_down_done ##0 q.off_level[q.down_cause]
		|=> (q.int_ctrl == INT_CTRL_RST) && (q.up_len0 == UP_LEN0_RST)
		&& (q.boot_status == '0))
		else $error("Hardware domain not cleared.");

	a_swo_clear: assert property (
		s_down_done |=> !q.keep_on && q.sleep_allow)
		else $error("Switch-off domain not cleared.");

	a_int_wake_sleep: assert property (
		(q.state == ST_SLEEP) && !q.int_ctrl[INT_MASK_SLEEP_BIT] && pending
		|=> !int_n_o)
		else $error("Unmasked interrupt in sleep not driven.");

	a_int_idle: assert property (
		!pending |=> int_n_o)
		else $error("Interrupt driven with nothing pending.");
endmodule : power_on_ack_reset_domains
`default_nettype wire

// File: hdl/pwr_ack_pkg.sv
// Constants and types for the power-on acknowledge and reset-domain block.
// Operation
// - Hold reset output until power-up sequence ends.
// - Pin-mode ON request starts power-up; reset low.
// - Pin mode shuts down after 8 s unless held.
// - Keep-alive pin falling edge is an OFF request.
// - Automatic mode sets keep-on bit after power-up.
// - Automatic mode stays active until bit cleared.
// - Auto-set can be disabled; bit replaces pin.
// - Boot pin selects configuration region and selector.
// - Boot pin latched into boot status on power-up.
// - Sequence branches on live boot pin level.
// - Settings writable only while no sequence runs.
// - Power-on reset clears all three domains.
// - Power-on domain survives hardware and switch-off resets.
// - Hardware-reset OFF request runs power-down to OFF.
// - Hardware reset clears hardware and switch-off domains.
// - Hardware domain holds configuration and interrupt control.
// - Other OFF requests clear switch-off domain only.
// - Switch-off domain holds device and power control.
// - Interrupt output push-pull, low while pending.
// - Interrupt masked in sleep by default, configurable.
package pwr_ack_pkg;
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned TICK_NS = 1000000;
	localparam int unsigned TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned TICK_W = 15;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned ACTIVE_WINDOW_S = 8;
	localparam int unsigned WIN_W = 13;
	localparam logic [WIN_W-1:0] ACTIVE_WINDOW_TICKS =
		WIN_W'(ACTIVE_WINDOW_S * MS_PER_S);
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned STEP_W = 8;
	localparam int unsigned CFG_W = 7;
	localparam int unsigned SRC_W = 4;
	localparam logic [ADDR_W-1:0] ADDR_DEVICE_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_POWER_CTRL = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_MODE = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_OFF_LEVEL = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_UP_LEN0 = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_UP_LEN1 = 4'h5;
	localparam logic [ADDR_W-1:0] ADDR_DOWN_LEN = 4'h6;
	localparam logic [ADDR_W-1:0] ADDR_INT_CTRL = 4'h7;
	localparam logic [ADDR_W-1:0] ADDR_BOOT_STATUS = 4'h8;
	localparam logic [ADDR_W-1:0] ADDR_OFF_CAUSE = 4'h9;
	localparam logic [ADDR_W-1:0] ADDR_CONV_MASK = 4'hA;
	localparam logic [ADDR_W-1:0] ADDR_STATE = 4'hB;
	localparam int unsigned KEEP_ON_BIT = 0;
	localparam int unsigned SLEEP_ALLOW_BIT = 0;
	localparam int unsigned AUTO_MODE_BIT = 0;
	localparam int unsigned AUTO_SET_DIS_BIT = 1;
	localparam int unsigned INT_MASK_SLEEP_BIT = 0;
	localparam int unsigned INT_SRC_MASK_LSB = 4;
	localparam int unsigned CAUSE_WINDOW = 0;
	localparam int unsigned CAUSE_HOLD_FALL = 1;
	localparam logic [DATA_W-1:0] MODE_RST = 8'h00;
	localparam logic [DATA_W-1:0] OFF_LEVEL_RST = 8'h03;
	localparam logic [DATA_W-1:0] UP_LEN0_RST = 8'h04;
	localparam logic [DATA_W-1:0] UP_LEN1_RST = 8'h06;
	localparam logic [DATA_W-1:0] DOWN_LEN_RST = 8'h03;
	localparam logic [DATA_W-1:0] INT_CTRL_RST = 8'h01;
	localparam logic [CFG_W-1:0] REGION0_BASE = 7'h00;
	localparam logic [CFG_W-1:0] REGION1_BASE = 7'h30;
	localparam logic [CFG_W-1:0] REGION_SPAN = 7'h2F;
	localparam int unsigned SYNC_ON = 0;
	localparam int unsigned SYNC_HOLD = 1;
	localparam int unsigned SYNC_BOOT = 2;
	localparam int unsigned SYNC_SLEEP = 3;
	localparam int unsigned NSYNC = 4;

	typedef enum logic [4:0] {
		ST_OFF = 5'b00001,
		ST_UP = 5'b00010,
		ST_ACTIVE = 5'b00100,
		ST_SLEEP = 5'b01000,
		ST_DOWN = 5'b10000
	} state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic [CFG_W-1:0] cfg_addr;
		logic seq_sel;
		logic running;
		logic down_from_sleep;
	} seq_out_t;

	typedef struct packed {
		state_t state;
		logic [NSYNC-1:0] sync1;
		logic [NSYNC-1:0] sync2;
		logic hold_prev;
		logic on_prev;
		logic [TICK_W-1:0] tick_cnt;
		logic tick;
		logic [WIN_W-1:0] win_cnt;
		logic win_done;
		logic [STEP_W-1:0] step;
		logic down_cause;
		seq_out_t seq;
		logic keep_on;
		logic sleep_allow;
		logic [DATA_W-1:0] mode;
		logic [DATA_W-1:0] off_level;
		logic [DATA_W-1:0] up_len0;
		logic [DATA_W-1:0] up_len1;
		logic [DATA_W-1:0] down_len;
		logic [DATA_W-1:0] int_ctrl;
		logic [DATA_W-1:0] boot_status;
		logic [DATA_W-1:0] off_cause;
		logic [DATA_W-1:0] conv_mask;
		logic [DATA_W-1:0] rdata;
		logic reset_out;
		logic int_n;
	} core_t;

	localparam core_t CORE_RST = '{state: ST_OFF, sleep_allow: 1'b1,
		mode: MODE_RST, off_level: OFF_LEVEL_RST, up_len0: UP_LEN0_RST,
		up_len1: UP_LEN1_RST, down_len: DOWN_LEN_RST,
		int_ctrl: INT_CTRL_RST, int_n: 1'b1, default: '0};
endpackage : pwr_ack_pkg

// File: tb/host_model.sv
// Host processor model that acknowledges power-up on the keep-alive pin.
`timescale 1ns/1ns
`default_nettype none
module host_model (
	input wire logic clk_i,
	input wire logic reset_out_i,
	input wire logic hold_en_i,
	input wire logic [3:0] delay_i,
	output logic keep_alive_pin_o
);
	logic [3:0] cnt_q;

	// The pin rises a few cycles late on purpose, as a real host would.
	always @(posedge clk_i) begin
		if (!hold_en_i) begin
			keep_alive_pin_o <= 1'h0;
			cnt_q <= 4'h0;
		end else if (reset_out_i && cnt_q != delay_i) begin
			cnt_q <= cnt_q + 4'h1;
		end else if (reset_out_i) begin
			keep_alive_pin_o <= 1'h1;
		end
	end
endmodule : host_model
`default_nettype wire

// File: tb/tb_power_on_ack_reset_domains.sv
// Self-checking bench for the power acknowledge and reset domain block.
`timescale 1ns/1ns
`default_nettype none
module tb_power_on_ack_reset_domains;
	import pwr_ack_pkg::*;
	localparam int TK = 4;
	logic clk_i, rst_i, on_i, boot_i, slp_i, hold_en, pin, rst_o, int_n;
	reg_req_t req;
	logic [DATA_W-1:0] rdata;
	logic [SRC_W-1:0] src, m;
	logic [3:0] dly;
	seq_out_t seq;
	int n_mismatch = 0;
	int checks = 0;
	int seed = 51;
	int cyc = 0;
	int c;
	logic [DATA_W-1:0] rst_tab [13] = '{8'h00, 8'h01, MODE_RST,
		OFF_LEVEL_RST, UP_LEN0_RST, UP_LEN1_RST, DOWN_LEN_RST,
		INT_CTRL_RST, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};

	power_on_ack_reset_domains #(.TICK_CYCLES(TK)) dut (.clk_i(clk_i),
		.rst_i(rst_i), .reg_req_i(req), .reg_rdata_o(rdata),
		.on_request_i(on_i), .keep_alive_pin_i(pin),
		.boot_sel_i(boot_i), .sleep_request_i(slp_i), .int_src_i(src),
		.reset_out_o(rst_o), .int_n_o(int_n), .seq_o(seq));
	host_model host (.clk_i(clk_i), .reset_out_i(rst_o),
		.hold_en_i(hold_en), .delay_i(dly), .keep_alive_pin_o(pin));

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'h0;
		forever #25 clk_i = ~clk_i;
	end

	// The window test alone needs some 32000 cycles.
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude

	task automatic chk(string name, logic [31:0] e, logic [31:0] g);
		checks++;
		if (e !== g) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", name, e, g);
		end
	endtask : chk

	// A gap cycle follows each access so no strobe is driven twice at once.
	task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
		req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
		@(posedge clk_i);
		req <= '0;
		@(posedge clk_i);
	endtask : wr

	task automatic rc(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
		req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
		@(posedge clk_i);
		req <= '0;
		#1 chk($sformatf("reg %h", a), e, rdata);
		@(posedge clk_i);
	endtask : rc

	task automatic wait_rst(logic v, int n);
		c = 0;
		while (rst_o !== v && c < n) begin
			@(posedge clk_i);
			#1 c++;
		end
		chk("reset_out", v, rst_o);
	endtask : wait_rst

	task automatic power_up(logic b, int len);
		logic [CFG_W-1:0] base;
		base = b ? REGION1_BASE : REGION0_BASE;
		boot_i <= b;
		on_i <= 1'h1;
		repeat (5) @(posedge clk_i);
		on_i <= 1'h0;
		#1 chk("running", 1'h1, seq.running);
		chk("select", b, seq.seq_sel);
		chk("region", 1'h1, seq.cfg_addr >= base &&
			seq.cfg_addr <= base + REGION_SPAN);
		chk("reset held", 1'h0, rst_o);
		wr(ADDR_DOWN_LEN, 8'h0E);
		wait_rst(1'h1, 80);
		chk("up time", 1'h1, c + 7 >= 3 + (len - 1) * TK &&
			c + 7 <= 6 + len * TK);
		rc(ADDR_BOOT_STATUS, {7'h00, b});
		rc(ADDR_STATE, 8'h04);
	endtask : power_up

	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_i = 1'h1;
		req = '0;
		on_i = 1'h0;
		boot_i = 1'h0;
		slp_i = 1'h0;
		hold_en = 1'h0;
		src = 4'h0;
		dly = 4'h3;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		for (int i = 0; i < 13; i++) rc(ADDR_W'(i), rst_tab[i]);
		#1 chk("int idle", 1'h1, int_n);
		for (int i = 0; i < 8; i++) begin
			m = SRC_W'($random(seed));
			wr(ADDR_INT_CTRL, {m, 4'h1});
			src <= SRC_W'($random(seed));
			repeat (3) @(posedge clk_i);
			#1 chk("int", (src & ~m) == 4'h0, int_n);
		end
		wr(ADDR_INT_CTRL, 8'h01);
		src <= 4'h0;
		// Hardware level off after a pin fall.
		wr(ADDR_CONV_MASK, 8'h5A);
		wr(ADDR_UP_LEN1, 8'h0A);
		dly <= 4'($random(seed));
		hold_en <= 1'h1;
		power_up(1'h1, 10);
		rc(ADDR_DOWN_LEN, 8'h03);
		wr(ADDR_DOWN_LEN, 8'h02);
		rc(ADDR_DOWN_LEN, 8'h02);
		src <= 4'h1;
		slp_i <= 1'h1;
		repeat (6) @(posedge clk_i);
		rc(ADDR_STATE, 8'h08);
		#1 chk("int sleep", 1'h1, int_n);
		wr(ADDR_INT_CTRL, 8'h00);
		repeat (2) @(posedge clk_i);
		#1 chk("int sleep", 1'h0, int_n);
		src <= 4'h0;
		slp_i <= 1'h0;
		repeat (6) @(posedge clk_i);
		rc(ADDR_STATE, 8'h04);
		hold_en <= 1'h0;
		wait_rst(1'h0, 8);
		chk("from sleep", 1'h0, seq.down_from_sleep);
		rc(ADDR_OFF_CAUSE, 8'h02);
		repeat (24) @(posedge clk_i);
		rc(ADDR_STATE, 8'h01);
		rc(ADDR_DOWN_LEN, 8'h03);
		rc(ADDR_INT_CTRL, 8'h01);
		rc(ADDR_UP_LEN1, 8'h06);
		rc(ADDR_CONV_MASK, 8'h5A);
		rc(ADDR_OFF_CAUSE, 8'h02);
		// Switch-off level keeps the hardware domain.
		wr(ADDR_OFF_LEVEL, 8'h00);
		wr(ADDR_POWER_CTRL, 8'h00);
		wr(ADDR_OFF_CAUSE, 8'hFF);
		rc(ADDR_OFF_CAUSE, 8'h00);
		hold_en <= 1'h1;
		power_up(1'h0, 4);
		slp_i <= 1'h1;
		repeat (20) @(posedge clk_i);
		rc(ADDR_STATE, 8'h04);
		slp_i <= 1'h0;
		hold_en <= 1'h0;
		wait_rst(1'h0, 8);
		repeat (24) @(posedge clk_i);
		rc(ADDR_POWER_CTRL, 8'h01);
		rc(ADDR_OFF_LEVEL, 8'h00);
		// Automatic acknowledge, then with auto-set disabled.
		wr(ADDR_MODE, 8'h01);
		power_up(1'h0, 4);
		rc(ADDR_DEVICE_CTRL, 8'h01);
		repeat (200) @(posedge clk_i);
		#1 chk("auto hold", 1'h1, rst_o);
		wr(ADDR_DEVICE_CTRL, 8'h00);
		wait_rst(1'h0, 8);
		repeat (24) @(posedge clk_i);
		wr(ADDR_MODE, 8'h03);
		power_up(1'h0, 4);
		rc(ADDR_DEVICE_CTRL, 8'h00);
		wr(ADDR_DEVICE_CTRL, 8'h01);
		repeat (50) @(posedge clk_i);
		#1 chk("bit hold", 1'h1, rst_o);
		slp_i <= 1'h1;
		repeat (6) @(posedge clk_i);
		rc(ADDR_STATE, 8'h08);
		wr(ADDR_DEVICE_CTRL, 8'h00);
		wait_rst(1'h0, 8);
		chk("from sleep", 1'h1, seq.down_from_sleep);
		slp_i <= 1'h0;
		repeat (24) @(posedge clk_i);
		// Window expiry with no acknowledge at all.
		wr(ADDR_MODE, 8'h00);
		power_up(1'h0, 4);
		wait_rst(1'h0, ACTIVE_WINDOW_S * MS_PER_S * TK + 20);
		chk("window", 1'h1, c + 12 >= ACTIVE_WINDOW_S * MS_PER_S * TK &&
			c <= ACTIVE_WINDOW_S * MS_PER_S * TK + TK);
		rc(ADDR_OFF_CAUSE, 8'h03);
		rst_i <= 1'h1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		rc(ADDR_CONV_MASK, 8'h00);
		rc(ADDR_OFF_CAUSE, 8'h00);
		conclude();
	end
endmodule : tb_power_on_ack_reset_domains
`default_nettype wire
